// ==== verilog/sspi_regs.svh ====
// register map, field positions, reset values of the serial channel
`ifndef SSPI_REGS_SVH
`define SSPI_REGS_SVH
`define SSPI_DATA_OFS   8'h00
`define SSPI_MODE_OFS   8'h04
`define SSPI_STAT_OFS   8'h08
`define SSPI_TRIG_OFS   8'h0c
`define SSPI_BAUD_LSB   9
`define SSPI_MODE_ISRC  0
`define SSPI_MODE_TXEN  1
`define SSPI_MODE_DLEN  2
`define SSPI_MODE_DIR   3
`define SSPI_MODE_CKP   4
`define SSPI_MODE_DAP   5
`define SSPI_MODE_PLSB  8
`define SSPI_MODE_PMSB  11
`define SSPI_STAT_BUSY  0
`define SSPI_STAT_BFF   1
`define SSPI_STAT_OVF   2
`define SSPI_STAT_RUN   3
`define SSPI_TRIG_START 0
`define SSPI_TRIG_STOP  1
`define SSPI_MODE_RST   32'h0000_0006
`define SSPI_PRESC_W    15
`endif

// ==== verilog/sspi_pkg.sv ====
// types shared by the serial channel modules
package sspi_pkg;
  typedef enum logic {idle_st, shift_st} sspi_state_type;
endpackage : sspi_pkg

// ==== verilog/sspi_div_if.sv ====
// carrier between the channel core and its rate divider
interface sspi_div_if #(parameter int BAUD_W = 7);
  logic                run;
  logic [3:0]          presc;
  logic [BAUD_W-1:0]   baud;
  logic                tick;
  modport ctrl (output run, presc, baud, input tick);
  modport div  (input run, presc, baud, output tick);
endinterface : sspi_div_if

// ==== verilog/sspi_baud_div.sv ====
// prescaler and baud divisor producing half-period enable pulses
module sspi_baud_div #(
  parameter int PRE_W  = 15,
  parameter int BAUD_W = 7
) (
  input  wire logic pclk,     // system clock
  input  wire logic presetn,  // async reset, active low
  sspi_div_if.div   dv        // rate settings in, tick out
);
  logic [PRE_W-1:0]  pre_cnt_q;
  logic [BAUD_W-1:0] baud_cnt_q;
  logic [PRE_W-1:0]  pre_lim;
  logic              pre_tick;

  if (PRE_W < 15) begin : g_chk
    $error("prescaler too narrow for exponent 15");
  end

  // half period = 2**presc * (baud+1) clocks
  assign pre_lim  = PRE_W'((32'h1 << dv.presc) - 32'h1);
  assign pre_tick = (pre_cnt_q == pre_lim);
  assign dv.tick  = dv.run & pre_tick & (baud_cnt_q == dv.baud);

  // prescaler; restarts each frame so first half is full length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= '0;
    end else if (!dv.run || pre_tick) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end

  // baud divisor counts prescaler pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_q <= '0;
    end else if (!dv.run) begin
      baud_cnt_q <= '0;
    end else if (pre_tick) begin
      if (baud_cnt_q == dv.baud) begin
        baud_cnt_q <= '0;
      end else begin
        baud_cnt_q <= baud_cnt_q + 1'b1;
      end
    end
  end
endmodule : sspi_baud_div

// ==== verilog/sspi_channel.sv ====
// serial master channel core with apb register slave
//
// Notes on behaviour
// - frames of seven or eight data bits
// - rate from clk/2 down to clk/(2*2^15*128)
// - clock polarity bit inverts serial clock
// - msb-first or lsb-first shifting
// - overrun is the only status error; unmapped access flags pslverr
// - single mode interrupts at transfer end
// - continuous mode interrupts on buffer empty
// - low data byte write starts frame
// - received byte read from data bits 7:0
// - write while buffer full overwrites pending
// - pending transmit byte reads back harmlessly
// - source select changeable before last bit
// - stop trigger leaves operating state
// - frame end raises transfer-end interrupt in single mode only
// - data phase picks lead half period
// - length field: 0 seven, 1 eight bits
// - data upper bits hold baud divisor
`include "sspi_regs.svh"
module sspi_channel #(
  parameter int BAUD_W = 7
) (
  input  wire logic        pclk,                 // system clock
  input  wire logic        presetn,              // async reset, low
  input  wire logic        psel,                 // apb select
  input  wire logic        penable,              // apb access phase
  input  wire logic        pwrite,               // apb direction
  input  wire logic [7:0]  paddr,                // apb byte address
  input  wire logic [31:0] pwdata,               // apb write data
  input  wire logic [3:0]  pstrb,                // apb byte strobes
  output logic      [31:0] prdata,               // apb read data
  output logic             pready,               // apb ready
  output logic             pslverr,              // unmapped address
  output logic             serial_clock_output,  // serial clock pin
  output logic             serial_data_output,   // serial data pin
  input  wire logic        serial_data_input,    // serial data in pin
  output logic             channel_irq           // one-cycle event
);
  sspi_pkg::sspi_state_type state_q;
  logic [7:0]        tx_q, rx_q, sh_q, sh_next, rx_byte, prdata_q;
  logic [BAUD_W-1:0] baud_q;
  logic [3:0]        presc_q, ph_q, last_ph;
  logic [2:0]        top_idx;
  logic isrc_q, txen_q, dlen_q, dir_q, ckp_q, dap_q;
  logic bff_q, ovf_q, unread_q, run_q, rxbit_q, irq_q;
  logic sck_q, sdo_q, sdi_s1_q, sdi_s2_q, tick;
  logic setup, acc, wr, rd, hit, wr_data_lo, stop_wr;
  logic load, frame_done, rd_rx, ovf_clr;

  sspi_div_if #(.BAUD_W(BAUD_W)) div_bus ();

  if (BAUD_W < 1 || BAUD_W > 7) begin : g_chk
    $error("baud divisor must fit data bits 15:9");
  end

  // apb decode; zero wait states, errors on unmapped words
  assign setup   = psel & ~penable;
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign hit     = (paddr == `SSPI_DATA_OFS) | (paddr == `SSPI_MODE_OFS) |
                   (paddr == `SSPI_STAT_OFS) | (paddr == `SSPI_TRIG_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign wr_data_lo = wr & (paddr == `SSPI_DATA_OFS) & pstrb[0];
  assign stop_wr = wr & (paddr == `SSPI_TRIG_OFS) & pstrb[0] &
                   pwdata[`SSPI_TRIG_STOP];
  assign ovf_clr = wr & (paddr == `SSPI_STAT_OFS) & pstrb[0] &
                   pwdata[`SSPI_STAT_OVF];
  // a read of the receive byte only counts while nothing is pending
  assign rd_rx   = rd & (paddr == `SSPI_DATA_OFS) & ~bff_q;

  // frame geometry
  assign top_idx = dlen_q ? 3'h7 : 3'h6;
  assign last_ph = dlen_q ? 4'hf : 4'hd;
  assign frame_done = (state_q == sspi_pkg::shift_st) & tick &
                      (ph_q == last_ph);
  // start from idle, or chain straight on when a byte waits
  assign load = run_q & bff_q & ~stop_wr &
                ((state_q == sspi_pkg::idle_st) | frame_done);

  // next shift value, received bit enters at the far end
  always_comb begin
    sh_next = dir_q ? (sh_q >> 1) : (sh_q << 1);
    if (dir_q) begin
      sh_next[top_idx] = rxbit_q;
    end else begin
      sh_next[0] = rxbit_q;
    end
    rx_byte = {dlen_q & sh_next[7], sh_next[6:0]};
  end

  // rate divider runs only while a frame shifts
  assign div_bus.run   = (state_q == sspi_pkg::shift_st);
  assign div_bus.presc = presc_q;
  assign div_bus.baud  = baud_q;
  assign tick          = div_bus.tick;

  sspi_baud_div #(.PRE_W(`SSPI_PRESC_W), .BAUD_W(BAUD_W)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .dv      (div_bus.div)
  );

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dap_q, ckp_q, dir_q, dlen_q, txen_q, isrc_q} <= 6'h06;
      presc_q <= 4'h0;
      baud_q  <= '0;
    end else begin
      // source select may change mid-run; sampled at each event
      if (wr && paddr == `SSPI_MODE_OFS && pstrb[0]) begin
        isrc_q <= pwdata[`SSPI_MODE_ISRC];
        txen_q <= pwdata[`SSPI_MODE_TXEN];
        dlen_q <= pwdata[`SSPI_MODE_DLEN];
        dir_q  <= pwdata[`SSPI_MODE_DIR];
        ckp_q  <= pwdata[`SSPI_MODE_CKP];
        dap_q  <= pwdata[`SSPI_MODE_DAP];
      end
      if (wr && paddr == `SSPI_MODE_OFS && pstrb[1]) begin
        presc_q <= pwdata[`SSPI_MODE_PMSB:`SSPI_MODE_PLSB];
      end
      if (wr && paddr == `SSPI_DATA_OFS && pstrb[1]) begin
        baud_q <= pwdata[`SSPI_BAUD_LSB +: BAUD_W];
      end
    end
  end

  // operating state: start and stop triggers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (stop_wr) begin
      run_q <= 1'b0;
    end else if (wr && paddr == `SSPI_TRIG_OFS && pstrb[0] &&
                 pwdata[`SSPI_TRIG_START]) begin
      run_q <= 1'b1;
    end
  end

  // transmit buffer; a new write simply replaces a pending byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q  <= 8'h00;
      bff_q <= 1'b0;
    end else if (stop_wr) begin
      bff_q <= 1'b0;
    end else if (wr_data_lo && run_q) begin
      tx_q  <= pwdata[7:0];
      bff_q <= 1'b1;
    end else if (load) begin
      bff_q <= 1'b0;
    end
  end

  // shifter; sample at end of even halves, shift at end of odd ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sspi_pkg::idle_st;
      ph_q    <= 4'h0;
      sh_q    <= 8'h00;
      rxbit_q <= 1'b0;
    end else if (stop_wr) begin
      state_q <= sspi_pkg::idle_st;
      ph_q    <= 4'h0;
    end else begin
      case (state_q)
        sspi_pkg::idle_st: begin
          if (load) begin
            state_q <= sspi_pkg::shift_st;
            ph_q    <= 4'h0;
            sh_q    <= tx_q;
          end
        end
        sspi_pkg::shift_st: begin
          if (tick) begin
            ph_q <= ph_q + 4'h1;
            if (!ph_q[0]) begin
              rxbit_q <= sdi_s2_q;
            end else if (frame_done && load) begin
              ph_q <= 4'h0;
              sh_q <= tx_q;
            end else if (frame_done) begin
              state_q <= sspi_pkg::idle_st;
              ph_q    <= 4'h0;
              sh_q    <= sh_next;
            end else begin
              sh_q <= sh_next;
            end
          end
        end
        default: state_q <= sspi_pkg::idle_st;
      endcase
    end
  end

  // receive byte, unread marker and overrun; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q     <= 8'h00;
      unread_q <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      if (frame_done) begin
        rx_q     <= rx_byte;
        unread_q <= 1'b1;
      end else if (rd_rx) begin
        unread_q <= 1'b0;
      end
      if (frame_done && unread_q && !rd_rx) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // one interrupt event; source bit read at the moment it fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (load & isrc_q) |
               (frame_done & ~isrc_q);
    end
  end
  assign channel_irq = irq_q;

  // pins; both delayed by the same flop so they stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      sdo_q <= 1'b1;
    end else if (state_q == sspi_pkg::shift_st) begin
      sck_q <= (ph_q[0] ^ ~dap_q) ? ckp_q : ~ckp_q;
      sdo_q <= txen_q ? (dir_q ? sh_q[0] : sh_q[top_idx])
                      : ~ckp_q;
    end else begin
      sck_q <= ~ckp_q;
      sdo_q <= ~ckp_q;
    end
  end
  assign serial_clock_output = sck_q;
  assign serial_data_output  = sdo_q;

  // input synchroniser; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sdi_s1_q <= serial_data_input;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 8'h00;
    end else if (setup && !pwrite) begin
      case (paddr)
        `SSPI_DATA_OFS: prdata_q <= bff_q ? tx_q : rx_q;
        default:        prdata_q <= 8'h00;
      endcase
    end
  end
  logic [31:0] rd_word_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_word_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `SSPI_DATA_OFS: rd_word_q <= 32'(baud_q) << `SSPI_BAUD_LSB;
        `SSPI_MODE_OFS: rd_word_q <= {20'h00000, presc_q, 2'h0, dap_q,
                                      ckp_q, dir_q, dlen_q, txen_q, isrc_q};
        `SSPI_STAT_OFS: rd_word_q <= {28'h0000000, run_q, ovf_q, bff_q,
                                      state_q == sspi_pkg::shift_st};
        default:        rd_word_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata[31:0] = rd_word_q | {24'h000000, prdata_q};

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_tend: assert property (frame_done && !isrc_q |=> channel_irq)
    else $error("no transfer-end event");
  a_irq_bemp: assert property (load && isrc_q |=> channel_irq)
    else $error("no buffer-empty event");
  a_ovf_set: assert property (frame_done && unread_q && !rd_rx |=> ovf_q)
    else $error("overrun not flagged");
  a_buf_over: assert property (wr_data_lo && run_q && !stop_wr |=>
    bff_q && tx_q == $past(pwdata[7:0]))
    else $error("pending byte not replaced");
  a_stop_idle: assert property (stop_wr |=> !run_q && !bff_q &&
    state_q == sspi_pkg::idle_st)
    else $error("stop did not halt channel");
  a_sck_idle: assert property (state_q == sspi_pkg::idle_st &&
    $stable(ckp_q) && $past(state_q) == sspi_pkg::idle_st |->
    sck_q == !ckp_q)
    else $error("serial clock not idle");
  a_ph_range: assert property (state_q == sspi_pkg::shift_st |->
    ph_q <= last_ph)
    else $error("frame too long");
  a_rd_tx: assert property (setup && !pwrite && paddr == `SSPI_DATA_OFS
    && bff_q |=> prdata[7:0] == $past(tx_q))
    else $error("pending byte not read back");
  c_chain: cover property (frame_done && load);
  c_ovf: cover property (frame_done && unread_q);
  c_stop_mid: cover property (stop_wr && state_q == sspi_pkg::shift_st);
endmodule : sspi_channel

// ==== verif/sspi_slave_model.sv ====
// behavioural serial slave on the far side of the channel
module sspi_slave_model (
  input  wire logic       sck,    // serial clock from master
  input  wire logic       mosi,   // master data out
  input  wire logic       clr,    // resync bit counter
  input  wire logic       ckp,    // clock polarity
  input  wire logic       dap,    // data phase
  input  wire logic       lsb,    // lsb first
  input  wire logic       len8,   // eight-bit frames
  input  wire logic [7:0] tx,     // byte sent back
  output logic            miso,   // slave data out
  output logic      [7:0] got     // last byte captured
);
  int         i = 0;
  logic [7:0] sh = 8'h00;
  // capture on the master's sampling edge, then step to the next bit
  always @(sck or posedge clr) begin
    if (clr) begin
      i = 0;
    end else if (sck === (dap ? ckp : !ckp)) begin
      sh[lsb ? i : (len8 ? 7 : 6) - i] = mosi;
      i = i + 1;
      if (i == (len8 ? 8 : 7)) begin
        got = len8 ? sh : {1'b0, sh[6:0]};
        sh = 8'h00;
        i = 0;
      end
    end
  end
  // no select line: the next bit waits on the wire ahead of its edge
  assign miso = tx[lsb ? i : (len8 ? 7 : 6) - i];
endmodule : sspi_slave_model

// ==== verif/tb.sv ====
// self-checking bench for the serial master channel
`include "sspi_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] BAUD = 7'h09;  // 80 ns serial period
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, sck, sdo, sdi, irq, err;
  logic        clr = 0, ckp = 0, dap = 0, lsb = 0, len8 = 1;
  logic [7:0]  s_tx = 8'h00, got, v;
  int          error_cnt = 0, checks = 0, cyc = 0, irq_n = 0, k;
  int          t_wr = 0, t_irq = 0;
  logic [3:0]  strb = 4'hf;
  int          seed = 67736;
  logic [7:0]  exp_q[$];

  sspi_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_output(sck), .serial_data_output(sdo),
    .serial_data_input(sdi), .channel_irq(irq));
  sspi_slave_model slave (.sck(sck), .mosi(sdo), .clr(clr), .ckp(ckp),
    .dap(dap), .lsb(lsb), .len8(len8), .tx(s_tx), .miso(sdi), .got(got));

  always #2 pclk = ~pclk;
  // interrupt pulses are counted so none is lost during bus cycles
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pwrite && paddr == `SSPI_DATA_OFS) t_wr = cyc;
    if (irq === 1'b1) begin
      irq_n++;
      t_irq = cyc;
    end
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [7:0] msk(logic [7:0] x, logic l8);
    return l8 ? x : {1'b0, x[6:0]};
  endfunction : msk

  task automatic resync();
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
    @(posedge pclk);
  endtask : resync

  // one single-transfer frame; c picks ckp, dap, order, length, rx-only
  task automatic frame(logic [4:0] c);
    v = 8'($random(seed));
    {len8, lsb, dap, ckp} <= {c[3], c[2], c[1], c[0]};
    s_tx <= 8'($random(seed));
    // lsb-first frames also use the prescaler: 2 * (4+1) = 10 clocks a half
    apb(1, `SSPI_MODE_OFS,
        {23'h0, c[2], 2'h0, c[1], c[0], c[2], c[3], ~c[4], 1'b0});
    repeat (2) @(posedge pclk);
    chk("idle clock", {31'h0, ~c[0]}, {31'h0, sck});
    resync();
    k = irq_n;
    apb(1, `SSPI_TRIG_OFS, 32'h1);
    exp_q.push_back(msk(c[4] ? {8{~c[0]}} : v, c[3]));
    apb(1, `SSPI_DATA_OFS,
        {16'h0, c[2] ? 7'h04 : BAUD, 1'b0, v});
    while (irq_n == k) @(posedge pclk);
    apb(0, `SSPI_DATA_OFS, 32'h0);
    chk("rx byte", {24'h0, msk(s_tx, c[3])}, {24'h0, rd[7:0]});
    chk("slave saw", {24'h0, exp_q.pop_front()}, {24'h0, got});
    // write edge to event: load, 2N halves of 10 clocks, event register
    chk("frame cycles", c[3] ? 162 : 142, t_irq - t_wr);
  endtask : frame

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `SSPI_MODE_OFS, 32'h0);
    chk("mode reset", `SSPI_MODE_RST, rd);
    apb(0, `SSPI_STAT_OFS, 32'h0);
    chk("status reset", 32'h0, rd);
    apb(0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    for (int c = 0; c < 32; c++) frame(5'(c));
    // continuous mode: pending byte overwritten, then switch to end irq
    {len8, lsb, dap, ckp} <= 4'h8;
    s_tx <= 8'($random(seed));
    apb(1, `SSPI_MODE_OFS, 32'h7);
    resync();
    apb(1, `SSPI_TRIG_OFS, 32'h1);
    k = irq_n;
    apb(1, `SSPI_DATA_OFS, {16'h0, BAUD, 9'h0a5});
    apb(1, `SSPI_DATA_OFS, {16'h0, BAUD, 9'h03c});
    apb(0, `SSPI_DATA_OFS, 32'h0);
    chk("pending read", 32'h3c, {24'h0, rd[7:0]});
    apb(0, `SSPI_STAT_OFS, 32'h0);
    chk("buffer full", 32'h1, {31'h0, rd[`SSPI_STAT_BFF]});
    apb(1, `SSPI_DATA_OFS, {16'h0, BAUD, 9'h0c3});
    apb(1, `SSPI_MODE_OFS, 32'h6);
    while (irq_n < k + 3) @(posedge pclk);
    repeat (40) @(posedge pclk);
    chk("irq count", k + 3, irq_n);
    chk("last sent", 32'hc3, {24'h0, got});
    apb(0, `SSPI_STAT_OFS, 32'h0);
    chk("overrun", 32'h1, {31'h0, rd[`SSPI_STAT_OVF]});
    apb(0, `SSPI_DATA_OFS, 32'h0);
    chk("cont rx", {24'h0, s_tx}, {24'h0, rd[7:0]});
    apb(1, `SSPI_STAT_OFS, 32'h4);
    apb(1, `SSPI_MODE_OFS, 32'h7);
    // stop in mid-frame leaves the channel idle
    apb(1, `SSPI_DATA_OFS, {16'h0, BAUD, 9'h055});
    repeat (30) @(posedge pclk);
    apb(1, `SSPI_TRIG_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    apb(0, `SSPI_STAT_OFS, 32'h0);
    chk("stopped", 32'h0, {28'h0, rd[3:0]});
    chk("stop clock", 32'h1, {31'h0, sck});
    // full reinitialisation after a stop, as if the clock had been cut
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `SSPI_MODE_OFS, 32'h0);
    chk("mode reinit", `SSPI_MODE_RST, rd);
    // a data write on the baud lane alone must not start a frame
    apb(1, `SSPI_TRIG_OFS, 32'h1);
    strb <= 4'h2;
    apb(1, `SSPI_DATA_OFS, {16'h0, BAUD, 9'h0ff});
    strb <= 4'hf;
    apb(0, `SSPI_STAT_OFS, 32'h0);
    chk("lane1 only", 32'h8, {28'h0, rd[3:0]});
    end_sim();
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
endmodule : tb
